// >>> logic/bscl_pkg.sv
package bscl_pkg;
  // strap converter code width and ratio thresholds (code = ratio * 256)
  localparam int unsigned CODE_W = 8;
  // boundaries at gap centres so a gap code goes to the nearer range
  localparam logic [7:0] THR_019 = 8'h31;
  localparam logic [7:0] THR_029 = 8'h4a;
  localparam logic [7:0] THR_039 = 8'h64;
  localparam logic [7:0] THR_049 = 8'h7d;
  localparam logic [7:0] THR_059 = 8'h97;
  localparam logic [7:0] THR_069 = 8'hb0;
  localparam logic [7:0] THR_079 = 8'hca;
  localparam logic [7:0] THR_089 = 8'he3;
  // unique addresses (7 bit) per strap range
  localparam logic [6:0] P1_ADDR_0 = 7'h20;
  localparam logic [6:0] P1_ADDR_1 = 7'h21;
  localparam logic [6:0] P1_ADDR_2 = 7'h22;
  localparam logic [6:0] P1_ADDR_3 = 7'h23;
  localparam logic [6:0] P2_ADDR_0 = 7'h38;
  localparam logic [6:0] P2_ADDR_1 = 7'h3f;
  localparam logic [6:0] P2_ADDR_2 = 7'h4f;
  localparam logic [6:0] P2_ADDR_3 = 7'h48;
  // flash link
  localparam int unsigned SYS_MHZ = 125;
  localparam int unsigned SCK_MHZ = 12;
  localparam int unsigned SCK_HALF = (SYS_MHZ + 2 * SCK_MHZ - 1) / (2 * SCK_MHZ);
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [15:0] LOAD_BYTES = 16'h0010;
  localparam int unsigned RETRY_CYCLES = 1000;
  // core clock dividers per power state (from 24 MHz)
  localparam logic [2:0] DIV_ACTIVE = 3'h1;
  localparam logic [2:0] DIV_IDLE = 3'h4;

  typedef enum logic [2:0] {
    DBAT_NO_RESPONSE = 3'h0,
    DBAT_WAIT_SUPPLY_INT = 3'h1,
    DBAT_LOADER_WAIT_INT = 3'h2,
    DBAT_WAIT_SUPPLY_EXT = 3'h3,
    DBAT_LOADER_WAIT_EXT = 3'h4,
    DBAT_NO_WAIT = 3'h5
  } bscl_dbat_t;

  typedef enum logic [2:0] {
    CFG_SAFE = 3'h0,
    CFG_INF_WAIT = 3'h1,
    CFG_THREE = 3'h2,
    CFG_FIVE = 3'h3,
    CFG_RESERVED = 3'h4
  } bscl_cfg_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_IDLE = 2'h1,
    PWR_SLEEP = 2'h2
  } bscl_pwr_t;
endpackage

// >>> logic/bscl_top.sv
`timescale 1ns/1ps
`default_nettype none
module bscl_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic clk_slow_i,
  input wire logic [7:0] boot_strap_code_i,
  input wire logic [7:0] address_strap_code_i,
  input wire logic strap_valid_i,
  input wire logic flash_data_in_i,
  input wire logic main_supply_input_i,
  input wire logic [6:0] p1_addr_mask_i,
  input wire logic [6:0] p1_addr_ovr_i,
  input wire logic [6:0] p2_addr_mask_i,
  input wire logic [6:0] p2_addr_ovr_i,
  input wire logic addr_rw_i,
  input wire logic die_overtemp_i,
  input wire logic [1:0] path_overtemp_i,
  input wire logic path_auto_resume_i,
  input wire logic [1:0] path_fw_enable_i,
  input wire logic connected_i,
  input wire logic wake_event_i,
  input wire logic idle_req_i,
  input wire logic sleep_req_i,
  input wire logic pd_msg_i,
  output logic [7:0] p1_addr_byte_o,
  output logic [7:0] p2_addr_byte_o,
  output logic port_enable_o,
  output logic flash_clk_o,
  output logic flash_cs_b_o,
  output logic flash_data_out_o,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic config_loaded_o,
  output logic [2:0] dbat_mode_o,
  output logic [2:0] default_cfg_o,
  output logic sink_control_pin_o,
  output logic first_hv_power_path_o,
  output logic [1:0] path_on_o,
  output logic functions_on_o,
  output logic [1:0] pwr_state_o,
  output logic [2:0] core_div_o,
  output logic osc24_on_o,
  output logic pd_allowed_o,
  output logic serial_allowed_o,
  output logic spi_allowed_o,
  output logic pd_msg_o,
  output logic timer_tick_o
);
  // synchronisers for pin levels
  logic [1:0] miso_s_r, sup_s_r, dot_s_r, sv_s_r;
  logic [3:0] pot_s_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      miso_s_r <= 2'h0;
      sup_s_r <= 2'h0;
      dot_s_r <= 2'h0;
      sv_s_r <= 2'h0;
      pot_s_r <= 4'h0;
    end else begin
      miso_s_r <= {miso_s_r[0], flash_data_in_i};
      sup_s_r <= {sup_s_r[0], main_supply_input_i};
      dot_s_r <= {dot_s_r[0], die_overtemp_i};
      sv_s_r <= {sv_s_r[0], strap_valid_i};
      pot_s_r <= {pot_s_r[1:0], path_overtemp_i};
    end
  end
  wire logic miso = miso_s_r[1];
  wire logic supply_ok = sup_s_r[1];
  wire logic die_hot = dot_s_r[1];
  wire logic [1:0] path_hot = pot_s_r[3:2];

  // strap capture; codes are static once strap_valid rises
  logic straps_done_r;
  logic [1:0] addr_sel_r;
  logic [2:0] dbat_r, cfg_r;
  logic [2:0] dbat_nxt, cfg_nxt;
  logic [1:0] addr_sel_nxt;
  logic [7:0] bc, ac;
  always_comb begin
    bc = boot_strap_code_i;
    ac = address_strap_code_i;
    if (ac < bscl_pkg::THR_019) addr_sel_nxt = 2'h0;
    else if (ac < bscl_pkg::THR_039) addr_sel_nxt = 2'h1;
    else if (ac < bscl_pkg::THR_059) addr_sel_nxt = 2'h2;
    else addr_sel_nxt = 2'h3;
    if (miso) begin
      cfg_nxt = bscl_pkg::CFG_SAFE;
      if (bc < bscl_pkg::THR_019) dbat_nxt = bscl_pkg::DBAT_NO_RESPONSE;
      else if (bc < bscl_pkg::THR_029) dbat_nxt = bscl_pkg::DBAT_WAIT_SUPPLY_INT;
      else if (bc < bscl_pkg::THR_039) begin
        dbat_nxt = bscl_pkg::DBAT_LOADER_WAIT_INT;
        cfg_nxt = bscl_pkg::CFG_INF_WAIT;
      end else if (bc < bscl_pkg::THR_049) dbat_nxt = bscl_pkg::DBAT_WAIT_SUPPLY_EXT;
      else if (bc < bscl_pkg::THR_059) begin
        dbat_nxt = bscl_pkg::DBAT_LOADER_WAIT_EXT;
        cfg_nxt = bscl_pkg::CFG_INF_WAIT;
      end else dbat_nxt = bscl_pkg::DBAT_NO_WAIT;
    end else begin
      dbat_nxt = bscl_pkg::DBAT_NO_RESPONSE;
      cfg_nxt = bscl_pkg::CFG_INF_WAIT;
      if (bc >= bscl_pkg::THR_029 && bc < bscl_pkg::THR_039) begin
        dbat_nxt = bscl_pkg::DBAT_LOADER_WAIT_INT;
      end else if (bc >= bscl_pkg::THR_039 && bc < bscl_pkg::THR_049) begin
        dbat_nxt = bscl_pkg::DBAT_NO_WAIT;
        cfg_nxt = bscl_pkg::CFG_THREE;
      end else if (bc >= bscl_pkg::THR_049 && bc < bscl_pkg::THR_059) begin
        dbat_nxt = bscl_pkg::DBAT_LOADER_WAIT_EXT;
      end else if (bc >= bscl_pkg::THR_069 && bc < bscl_pkg::THR_079) begin
        dbat_nxt = bscl_pkg::DBAT_NO_WAIT;
        cfg_nxt = bscl_pkg::CFG_RESERVED;
      end else if (bc >= bscl_pkg::THR_089) begin
        dbat_nxt = bscl_pkg::DBAT_NO_WAIT;
        cfg_nxt = bscl_pkg::CFG_FIVE;
      end
    end
  end
  // latch converted codes once at power-up
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      straps_done_r <= 1'b0;
      addr_sel_r <= 2'h0;
      dbat_r <= 3'h0;
      cfg_r <= 3'h0;
    end else if (!straps_done_r && sv_s_r[1]) begin
      straps_done_r <= 1'b1;
      addr_sel_r <= addr_sel_nxt;
      dbat_r <= dbat_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  logic [6:0] p1_base, p2_base;
  always_comb begin
    unique case (addr_sel_r)
      2'h0: begin p1_base = bscl_pkg::P1_ADDR_0; p2_base = bscl_pkg::P2_ADDR_0; end
      2'h1: begin p1_base = bscl_pkg::P1_ADDR_1; p2_base = bscl_pkg::P2_ADDR_1; end
      2'h2: begin p1_base = bscl_pkg::P1_ADDR_2; p2_base = bscl_pkg::P2_ADDR_2; end
      2'h3: begin p1_base = bscl_pkg::P1_ADDR_3; p2_base = bscl_pkg::P2_ADDR_3; end
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p1_addr_byte_o <= 8'h00;
      p2_addr_byte_o <= 8'h00;
      port_enable_o <= 1'b0;
    end else begin
      // address above, rw in bit 0
      p1_addr_byte_o <= {(p1_base & ~p1_addr_mask_i) | (p1_addr_ovr_i & p1_addr_mask_i),
                         addr_rw_i};
      p2_addr_byte_o <= {(p2_base & ~p2_addr_mask_i) | (p2_addr_ovr_i & p2_addr_mask_i),
                         addr_rw_i};
      // command port answers only once enabled
      port_enable_o <= straps_done_r && functions_on_o && serial_allowed_o;
    end
  end

  // boot sequencer and flash loader
  typedef enum logic [2:0] {
    B_STRAP = 3'h0, B_HOLD = 3'h1, B_SHIFT = 3'h2, B_GAP = 3'h3,
    B_RETRY = 3'h4, B_DONE = 3'h5, B_FAIL = 3'h6
  } bscl_boot_t;
  bscl_boot_t boot_r;
  logic [7:0] half_r;
  logic [5:0] bit_r;
  logic [15:0] byte_r;
  logic [7:0] sh_r;
  logic [9:0] retry_r;
  wire logic loader_wait = dbat_r == bscl_pkg::DBAT_LOADER_WAIT_INT ||
                           dbat_r == bscl_pkg::DBAT_LOADER_WAIT_EXT;
  wire logic may_load = (dbat_r == bscl_pkg::DBAT_NO_WAIT || loader_wait || supply_ok)
                        && functions_on_o && spi_allowed_o;
  wire logic half_end = half_r == 8'(bscl_pkg::SCK_HALF - 1);
  // header: read command plus 24-bit zero address, then data
  wire logic in_hdr = byte_r < 16'h0004;
  // image fits within a 64 kB flash
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_r <= B_STRAP;
      half_r <= 8'h00;
      bit_r <= 6'h00;
      byte_r <= 16'h0000;
      sh_r <= 8'h00;
      retry_r <= 10'h000;
      flash_clk_o <= 1'b0;
      flash_cs_b_o <= 1'b1;
      flash_data_out_o <= 1'b0;
      load_data_o <= 8'h00;
      load_valid_o <= 1'b0;
      config_loaded_o <= 1'b0;
    end else begin
      load_valid_o <= 1'b0;
      half_r <= half_end ? 8'h00 : half_r + 8'h01;
      unique case (boot_r)
        B_STRAP: begin
          half_r <= 8'h00;
          if (straps_done_r && may_load) begin
            boot_r <= B_SHIFT;
            // select and present bit 7 together
            flash_cs_b_o <= 1'b0;
            flash_data_out_o <= bscl_pkg::FLASH_READ_CMD[7];
            bit_r <= 6'h00;
            byte_r <= 16'h0000;
          end
        end
        B_SHIFT: begin
          if (half_end) begin
            flash_clk_o <= ~flash_clk_o;
            if (!flash_clk_o) begin
              sh_r <= {sh_r[6:0], miso};
            end else begin
              bit_r <= bit_r + 6'h01;
              if (bit_r[2:0] == 3'h7) begin
                byte_r <= byte_r + 16'h0001;
                if (!in_hdr) begin
                  load_data_o <= sh_r;
                  load_valid_o <= 1'b1;
                end
                flash_data_out_o <= 1'b0;
                if (byte_r == bscl_pkg::LOAD_BYTES + 16'h0003) begin
                  boot_r <= B_DONE;
                  flash_cs_b_o <= 1'b1;
                end
              end else if (byte_r == 16'h0000) begin
                flash_data_out_o <= bscl_pkg::FLASH_READ_CMD[3'h6 - bit_r[2:0]];
              end else begin
                flash_data_out_o <= 1'b0;
              end
            end
          end
          if (!spi_allowed_o || !functions_on_o) begin
            flash_clk_o <= 1'b0;
            flash_cs_b_o <= 1'b1;
            boot_r <= loader_wait ? B_RETRY : B_FAIL;
            retry_r <= 10'h000;
          end
        end
        B_RETRY: begin
          retry_r <= retry_r + 10'h001;
          if (retry_r == 10'(bscl_pkg::RETRY_CYCLES - 1)) boot_r <= B_STRAP;
        end
        B_DONE: config_loaded_o <= 1'b1;
        B_FAIL: if (default_cfg_o != bscl_pkg::CFG_INF_WAIT) config_loaded_o <= 1'b0;
        default: boot_r <= B_STRAP;
      endcase
    end
  end
  // mode 0, half period rounds to 12 MHz or below

  logic [1:0] path_lock_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      functions_on_o <= 1'b0;
      path_lock_r <= 2'h0;
      path_on_o <= 2'h0;
      sink_control_pin_o <= 1'b0;
      first_hv_power_path_o <= 1'b0;
      dbat_mode_o <= 3'h0;
      default_cfg_o <= 3'h0;
    end else begin
      functions_on_o <= !die_hot;
      dbat_mode_o <= dbat_r;
      default_cfg_o <= cfg_r;
      for (int i = 0; i < 2; i++) begin
        if (path_hot[i]) path_lock_r[i] <= 1'b1;
        else if (path_auto_resume_i || path_fw_enable_i[i]) path_lock_r[i] <= 1'b0;
        path_on_o[i] <= !path_hot[i] && !path_lock_r[i] && !die_hot && config_loaded_o;
      end
      // external sink pin, internal first path
      sink_control_pin_o <= straps_done_r && !die_hot &&
        (dbat_r == bscl_pkg::DBAT_WAIT_SUPPLY_EXT || dbat_r == bscl_pkg::DBAT_LOADER_WAIT_EXT);
      first_hv_power_path_o <= straps_done_r && !die_hot && !path_hot[0] &&
        (dbat_r == bscl_pkg::DBAT_WAIT_SUPPLY_INT || dbat_r == bscl_pkg::DBAT_LOADER_WAIT_INT);
    end
  end

  // power states
  bscl_pkg::bscl_pwr_t pwr_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_r <= bscl_pkg::PWR_ACTIVE;
      pwr_state_o <= 2'h0;
      core_div_o <= 3'h0;
      osc24_on_o <= 1'b0;
      pd_allowed_o <= 1'b0;
      serial_allowed_o <= 1'b0;
      spi_allowed_o <= 1'b0;
      pd_msg_o <= 1'b0;
    end else begin
      pd_msg_o <= 1'b0;
      unique case (pwr_r)
        bscl_pkg::PWR_ACTIVE: begin
          if (pd_msg_i && pd_allowed_o) pd_msg_o <= 1'b1;
          if (sleep_req_i && !connected_i && config_loaded_o) pwr_r <= bscl_pkg::PWR_SLEEP;
          else if (idle_req_i && config_loaded_o) pwr_r <= bscl_pkg::PWR_IDLE;
        end
        bscl_pkg::PWR_IDLE: begin
          // the waking message is the lost one
          if (pd_msg_i || wake_event_i) pwr_r <= bscl_pkg::PWR_ACTIVE;
        end
        bscl_pkg::PWR_SLEEP: if (wake_event_i) pwr_r <= bscl_pkg::PWR_ACTIVE;
        default: pwr_r <= bscl_pkg::PWR_ACTIVE;
      endcase
      pwr_state_o <= pwr_r;
      core_div_o <= pwr_r == bscl_pkg::PWR_IDLE ? bscl_pkg::DIV_IDLE : bscl_pkg::DIV_ACTIVE;
      osc24_on_o <= pwr_r != bscl_pkg::PWR_SLEEP;
      pd_allowed_o <= pwr_r == bscl_pkg::PWR_ACTIVE;
      spi_allowed_o <= pwr_r == bscl_pkg::PWR_ACTIVE;
      serial_allowed_o <= pwr_r != bscl_pkg::PWR_SLEEP;
    end
  end

  // slow oscillator domain drives timer tick
  logic slow_tog_r;
  always_ff @(posedge clk_slow_i or negedge rst_b_i) begin
    if (!rst_b_i) slow_tog_r <= 1'b0;
    else slow_tog_r <= ~slow_tog_r;
  end
  // toggle crossing; an edge counts as one tick
  logic [2:0] tick_s_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_s_r <= 3'h0;
      timer_tick_o <= 1'b0;
    end else begin
      tick_s_r <= {tick_s_r[1:0], slow_tog_r};
      timer_tick_o <= tick_s_r[2] ^ tick_s_r[1];
    end
  end
endmodule
`default_nettype wire

// >>> tb/bscl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bscl_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [6:0] p1_addr_mask_i,
  input wire logic [6:0] p1_addr_ovr_i,
  input wire logic addr_rw_i,
  input wire logic die_overtemp_i,
  input wire logic [7:0] p1_addr_byte_o,
  input wire logic port_enable_o,
  input wire logic flash_clk_o,
  input wire logic flash_cs_b_o,
  input wire logic flash_data_out_o,
  input wire logic config_loaded_o,
  input wire logic [2:0] dbat_mode_o,
  input wire logic sink_control_pin_o,
  input wire logic first_hv_power_path_o,
  input wire logic functions_on_o,
  input wire logic [1:0] pwr_state_o,
  input wire logic [2:0] core_div_o,
  input wire logic osc24_on_o,
  input wire logic pd_allowed_o,
  input wire logic serial_allowed_o,
  input wire logic spi_allowed_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic ext_m;
  logic int_m;
  logic no_sw;
  assign ext_m = dbat_mode_o inside {bscl_pkg::DBAT_WAIT_SUPPLY_EXT, bscl_pkg::DBAT_LOADER_WAIT_EXT};
  assign int_m = dbat_mode_o inside {bscl_pkg::DBAT_WAIT_SUPPLY_INT, bscl_pkg::DBAT_LOADER_WAIT_INT};
  assign no_sw = !first_hv_power_path_o && !sink_control_pin_o;
  // sync stages plus register: five cycles of heat must have reached the output
  sequence s_hot;
    die_overtemp_i [*5];
  endsequence
  sequence s_idle2;
    pwr_state_o == bscl_pkg::PWR_IDLE [*2];
  endsequence
  sequence s_sleep2;
    pwr_state_o == bscl_pkg::PWR_SLEEP [*2];
  endsequence
  a_clk_idle_low: assert property (flash_cs_b_o |-> !flash_clk_o)
    else $error("serial clock high outside a frame");
  a_data_hold_high: assert property (!flash_cs_b_o && flash_clk_o |-> $stable(flash_data_out_o))
    else $error("flash data moved while clock high");
  a_frame_first_bit: assert property ($fell(flash_cs_b_o) |-> !flash_data_out_o && !flash_clk_o)
    else $error("first command bit not with select");
  a_loaded_after_frame: assert property ($rose(config_loaded_o) |-> $past(flash_cs_b_o) && flash_cs_b_o)
    else $error("config loaded while frame open");
  a_addr_override: assert property (port_enable_o && $past(port_enable_o) |->
    (((p1_addr_byte_o[7:1] ^ $past(p1_addr_ovr_i)) & $past(p1_addr_mask_i)) == 7'h0) &&
    (p1_addr_byte_o[0] == $past(addr_rw_i))) else $error("address byte ignores override");
  a_hot_funcs_off: assert property (s_hot |-> !functions_on_o)
    else $error("functions on while die hot");
  a_nowait_switch: assert property (dbat_mode_o == bscl_pkg::DBAT_NO_WAIT && !config_loaded_o |-> no_sw)
    else $error("switch closed before config");
  a_noresp_switch: assert property (dbat_mode_o == bscl_pkg::DBAT_NO_RESPONSE && !config_loaded_o |-> no_sw)
    else $error("switch closed in no-response");
  a_sink_route: assert property (!config_loaded_o |-> !(ext_m && first_hv_power_path_o) && !(int_m && sink_control_pin_o))
    else $error("sink path on wrong control");
  a_idle_features: assert property (s_idle2 |-> core_div_o == bscl_pkg::DIV_IDLE && !spi_allowed_o && !pd_allowed_o && serial_allowed_o)
    else $error("idle state features wrong");
  a_sleep_osc_off: assert property (s_sleep2 |-> !osc24_on_o && !serial_allowed_o && !spi_allowed_o)
    else $error("sleep state features wrong");
endmodule
bind bscl_top bscl_checker u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .p1_addr_mask_i(p1_addr_mask_i), .p1_addr_ovr_i(p1_addr_ovr_i), .addr_rw_i(addr_rw_i),
  .die_overtemp_i(die_overtemp_i), .p1_addr_byte_o(p1_addr_byte_o), .port_enable_o(port_enable_o),
  .flash_clk_o(flash_clk_o), .flash_cs_b_o(flash_cs_b_o), .flash_data_out_o(flash_data_out_o),
  .config_loaded_o(config_loaded_o), .dbat_mode_o(dbat_mode_o), .functions_on_o(functions_on_o),
  .sink_control_pin_o(sink_control_pin_o), .first_hv_power_path_o(first_hv_power_path_o),
  .pwr_state_o(pwr_state_o), .core_div_o(core_div_o), .osc24_on_o(osc24_on_o),
  .pd_allowed_o(pd_allowed_o), .serial_allowed_o(serial_allowed_o), .spi_allowed_o(spi_allowed_o));
`default_nettype wire

// >>> tb/bscl_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module bscl_flash_model (
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // 64 kB store; sectors not modelled, the loader never erases
  localparam int unsigned MEM_BYTES = 65536;
  logic [7:0] mem [MEM_BYTES];
  logic [31:0] hdr = 32'h0;
  int unsigned nbit = 0;
  int unsigned idx;
  initial begin
    miso_o = 1'b0;
    for (int a = 0; a < MEM_BYTES; a++)
      mem[a] = 8'(a) ^ 8'h5a;
  end
  always @(negedge cs_b_i) nbit = 0;
  always @(posedge sck_i) begin
    if (!cs_b_i) begin
      if (nbit < 32) hdr = {hdr[30:0], mosi_i};
      nbit = nbit + 1;
    end
  end
  // shift on falling; released line shows the inverse, a bad command all ones
  always @(negedge sck_i or posedge cs_b_i) begin
    idx = nbit - 32;
    if (cs_b_i) miso_o <= ~miso_o;
    else if (nbit >= 32) miso_o <= (hdr[31:24] == 8'h03) ? mem[16'(hdr[23:0] + idx / 8)][7 - idx % 8] : 1'b1;
  end
endmodule
`default_nettype wire

// >>> tb/bscl_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bscl_top_tb_top;
  logic clk_sys_i = 1'b0, clk_slow_i = 1'b0, rst_b_i = 1'b0;
  logic [7:0] boot_code = 8'h0, addr_code = 8'h0, p1_addr_byte_o, p2_addr_byte_o, load_data_o;
  logic strap_valid = 1'b0, strap_lvl = 1'b1, boot_phase = 1'b1, supply = 1'b0, rw = 1'b0;
  logic [6:0] m1 = 7'h0, o1 = 7'h0, m2 = 7'h0, o2 = 7'h0;
  logic hot = 1'b0, auto_res = 1'b0, conn = 1'b0, fdi, flash_miso;
  logic [3:0] req = 4'h0;
  logic [1:0] path_hot = 2'h0, fw_en = 2'h0, path_on_o, pwr_state_o;
  logic port_enable_o, flash_clk_o, flash_cs_b_o, flash_data_out_o, load_valid_o, config_loaded_o;
  logic [2:0] dbat_mode_o, default_cfg_o, core_div_o;
  logic sink_control_pin_o, first_hv_power_path_o, functions_on_o, osc24_on_o, pd_allowed_o;
  logic serial_allowed_o, spi_allowed_o, pd_msg_o, timer_tick_o;
  int n_mismatch = 0, n_tests = 0, n_pd = 0, n_tick = 0, seed = 32'h3ed3;
  logic [31:0] rv;
  logic [7:0] exp_q [$];
  logic [7:0] bc_t [7] = '{8'h17, 8'h3d, 8'h57, 8'h70, 8'h8a, 8'hcd, 8'h70};
  logic [7:0] ac_t [4] = '{8'h2e, 8'h33, 8'h8a, 8'hf0};
  logic [6:0] p1_t [4] = '{bscl_pkg::P1_ADDR_0, bscl_pkg::P1_ADDR_1, bscl_pkg::P1_ADDR_2, bscl_pkg::P1_ADDR_3};
  logic [6:0] p2_t [4] = '{bscl_pkg::P2_ADDR_0, bscl_pkg::P2_ADDR_1, bscl_pkg::P2_ADDR_2, bscl_pkg::P2_ADDR_3};
  logic [2:0] md_t [7] = '{bscl_pkg::DBAT_NO_RESPONSE, bscl_pkg::DBAT_WAIT_SUPPLY_INT,
    bscl_pkg::DBAT_LOADER_WAIT_INT, bscl_pkg::DBAT_WAIT_SUPPLY_EXT, bscl_pkg::DBAT_LOADER_WAIT_EXT,
    bscl_pkg::DBAT_NO_WAIT, bscl_pkg::DBAT_NO_WAIT};
  logic [2:0] cf_t [7] = '{bscl_pkg::CFG_SAFE, bscl_pkg::CFG_SAFE, bscl_pkg::CFG_INF_WAIT,
    bscl_pkg::CFG_SAFE, bscl_pkg::CFG_INF_WAIT, bscl_pkg::CFG_SAFE, bscl_pkg::CFG_THREE};
  logic [6:0] lv_t = 7'h3f, path_t = 7'h06, pin_t = 7'h18;
  // strap level shows on the data pin until ten cycles after strap_valid rises
  assign fdi = boot_phase ? strap_lvl : flash_miso;
  always #4 clk_sys_i = ~clk_sys_i;
  initial begin
    #13;
    forever #40 clk_slow_i = ~clk_slow_i;
  end
  bscl_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_slow_i(clk_slow_i),
    .boot_strap_code_i(boot_code), .address_strap_code_i(addr_code), .strap_valid_i(strap_valid),
    .flash_data_in_i(fdi), .main_supply_input_i(supply), .p1_addr_mask_i(m1), .p1_addr_ovr_i(o1),
    .p2_addr_mask_i(m2), .p2_addr_ovr_i(o2), .addr_rw_i(rw), .die_overtemp_i(hot),
    .path_overtemp_i(path_hot), .path_auto_resume_i(auto_res), .path_fw_enable_i(fw_en),
    .connected_i(conn), .idle_req_i(req[0]), .sleep_req_i(req[1]), .wake_event_i(req[2]),
    .pd_msg_i(req[3]), .p1_addr_byte_o(p1_addr_byte_o), .p2_addr_byte_o(p2_addr_byte_o),
    .port_enable_o(port_enable_o), .flash_clk_o(flash_clk_o), .flash_cs_b_o(flash_cs_b_o),
    .flash_data_out_o(flash_data_out_o), .load_data_o(load_data_o), .load_valid_o(load_valid_o),
    .config_loaded_o(config_loaded_o), .dbat_mode_o(dbat_mode_o), .default_cfg_o(default_cfg_o),
    .sink_control_pin_o(sink_control_pin_o), .first_hv_power_path_o(first_hv_power_path_o),
    .path_on_o(path_on_o), .functions_on_o(functions_on_o), .pwr_state_o(pwr_state_o),
    .core_div_o(core_div_o), .osc24_on_o(osc24_on_o), .pd_allowed_o(pd_allowed_o),
    .serial_allowed_o(serial_allowed_o), .spi_allowed_o(spi_allowed_o), .pd_msg_o(pd_msg_o),
    .timer_tick_o(timer_tick_o));
  bscl_flash_model flash (.sck_i(flash_clk_o), .cs_b_i(flash_cs_b_o), .mosi_i(flash_data_out_o),
    .miso_o(flash_miso));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wait_clk(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task boot(input logic [7:0] bc, input logic [7:0] ac, input logic lvl);
    rst_b_i = 1'b0;
    strap_valid = 1'b0;
    boot_phase = 1'b1;
    {boot_code, addr_code, strap_lvl} = {bc, ac, lvl};
    wait_clk(8);
    rst_b_i = 1'b1;
    wait_clk(2);
    strap_valid = 1'b1;
    wait_clk(10);
    boot_phase = 1'b0;
  endtask
  task pulse(input logic [3:0] p);
    req = p;
    wait_clk(1);
    req = 4'h0;
    wait_clk(6);
  endtask
  // result side: every streamed byte takes the oldest expectation
  always @(negedge clk_sys_i) begin
    if (rst_b_i === 1'b1 && load_valid_o === 1'b1) check(load_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    if (pd_msg_o === 1'b1) n_pd++;
    if (timer_tick_o === 1'b1) n_tick++;
  end
  // whole run is about 2400 cycles; the 40000-cycle limit means a hang
  initial begin
    #320000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    for (int i = 0; i < 7; i++) begin
      boot(bc_t[i], ac_t[i % 4], lv_t[i]);
      wait_clk(20);
      check(dbat_mode_o, md_t[i]);
      check(default_cfg_o, cf_t[i]);
      check(p1_addr_byte_o, {p1_t[i % 4], 1'b0});
      check(p2_addr_byte_o, {p2_t[i % 4], 1'b0});
      check(first_hv_power_path_o, path_t[i]);
      check(sink_control_pin_o, pin_t[i]);
      if (i == 1 || i == 3) check(flash_cs_b_o, 1'b1);
    end
    for (int k = 0; k < 16; k++)
      exp_q.push_back(8'(k) ^ 8'h5a);
    boot(8'hcd, 8'hf0, 1'b1);
    for (int w = 0; w < 6000 && config_loaded_o !== 1'b1; w++)
      wait_clk(1);
    check(config_loaded_o, 1'b1);
    check(8'(exp_q.size()), 8'h0);
    repeat (4) begin
      rv = $random(seed);
      {rw, o2, m2, o1, m1} = rv[28:0];
      wait_clk(3);
      check(p1_addr_byte_o, {(bscl_pkg::P1_ADDR_3 & ~m1) | (o1 & m1), rw});
      check(p2_addr_byte_o, {(bscl_pkg::P2_ADDR_3 & ~m2) | (o2 & m2), rw});
    end
    {m1, o1, m2, o2} = 28'h0;
    hot = 1'b1;
    wait_clk(6);
    check(functions_on_o, 1'b0);
    hot = 1'b0;
    path_hot = 2'h1;
    wait_clk(6);
    check(functions_on_o, 1'b1);
    check(path_on_o[0], 1'b0);
    path_hot = 2'h0;
    wait_clk(6);
    check(path_on_o[0], 1'b0);
    fw_en = 2'h1;
    wait_clk(2);
    fw_en = 2'h0;
    pulse(4'h1);
    check(pwr_state_o, bscl_pkg::PWR_IDLE);
    check({spi_allowed_o, pd_allowed_o, serial_allowed_o}, 8'h1);
    pulse(4'h8);
    check(pwr_state_o, bscl_pkg::PWR_ACTIVE);
    check(8'(n_pd), 8'h0);
    pulse(4'h8);
    check(8'(n_pd), 8'h1);
    conn = 1'b1;
    pulse(4'h2);
    check(pwr_state_o, bscl_pkg::PWR_ACTIVE);
    conn = 1'b0;
    pulse(4'h2);
    check(pwr_state_o, bscl_pkg::PWR_SLEEP);
    check(osc24_on_o, 1'b0);
    pulse(4'h4);
    check(pwr_state_o, bscl_pkg::PWR_ACTIVE);
    check(core_div_o, bscl_pkg::DIV_ACTIVE);
    n_tick = 0;
    wait_clk(100);
    check({7'h0, n_tick >= 9 && n_tick <= 11}, 8'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
